// ==== logic/pfh_pkg.sv ====
package pfh_pkg;
   // Core clock
   localparam int CLK_PERIOD_NS = 10;
   // Device timing figures
   localparam int T_ACC_NS = 120;
   localparam int T_WP_NS  = 200;
   localparam int T_WPH_NS = 200;
   localparam int T_DF_NS  = 30;
   localparam int T_BLC_US = 150;
   localparam int T_WC_MS  = 20;
   // Cycle counts: least times round up, longest times round down
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DF_CYC  = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLC_CYC = (T_BLC_US * 1000) / CLK_PERIOD_NS;
   localparam int WC_CYC  = (T_WC_MS * 1000000) / CLK_PERIOD_NS;
   // Load window guard and counter sizes
   localparam int BLC_MARGIN = 4;
   localparam int SINCE_W    = 25;
   localparam int CNT_W      = 5;
   // Sector layout
   localparam int CMD_BYTES    = 3;
   localparam int SECTOR_BYTES = 128;
   localparam int SECTOR_LSB   = 7;
   localparam int ID_LINE_BIT  = 9;
   localparam int POLL_BIT     = 7;
   // Commands taken on the user port
   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_ID    = 2'h1,
      OP_WRITE = 2'h2,
      OP_PROG  = 2'h3
   } pfh_op_t;
   // Controller states, one-hot
   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_SETUP = 7'h02,
      S_WLOW  = 7'h04,
      S_WHIGH = 7'h08,
      S_WAIT  = 7'h10,
      S_READ  = 7'h20,
      S_RECOV = 7'h40
   } pfh_state_t;
endpackage : pfh_pkg

// ==== logic/pfh_flash_host.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Byte load: select low, write low, host drives
// - Hardware ID: elevated line, upper lines low
// - Wait for completion or program cycle maximum
// - Next load falls within load window
// - Output drive high while writing
// - Sector number on upper lines each sector byte load
// - Command prefix begins every program
module pfh_flash_host
   import pfh_pkg::*;
#(
   parameter int unsigned BLC_LIMIT = BLC_CYC,
   parameter int unsigned WC_LIMIT  = WC_CYC,
   parameter logic [47:0] CMD_ADDRS = 48'h0003_0002_0001,
   parameter logic [23:0] CMD_DATA  = 24'h03_0201
)(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Command port
   input  wire logic        cmd_valid,
   input  wire logic [1:0]  cmd_op,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   output logic             busy,
   // Sector byte stream
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_data,
   output logic             byte_ready,
   // Results
   output logic             rd_valid,
   output logic [7:0]       rd_data,
   output logic             done,
   output logic             err_window,
   output logic             err_poll,
   // Flash pins
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic [15:0]      flash_addr,
   output logic [7:0]       flash_dq_out,
   output logic             flash_dq_oe,
   input  wire logic [7:0]  flash_dq_in,
   output logic             id_hv_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks
   if (BLC_LIMIT < 64 || WC_LIMIT < 2 ||
       BLC_LIMIT + WC_LIMIT >= (1 << (SINCE_W - 1))) begin : g_bad
      $error("pfh_flash_host: timer limits out of range");
   end

   pfh_state_t             state;
   pfh_op_t                op;
   logic [CNT_W-1:0]       cnt;
   logic [7:0]             idx;
   logic [15:0]            base;
   logic [15:0]            last_addr;
   logic [7:0]             last_data;
   logic                   polling;
   logic [SINCE_W-1:0]     since_we;

   ////////////////////////////////////////////////////////////////////////////
   // Time since last write strobe rise, load window and cycle limit
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         since_we <= '0;
      end else if (!flash_we_n) begin
         since_we <= '0;
      end else if (!since_we[SINCE_W-1]) begin
         since_we <= since_we + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and pin drive
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state        <= S_IDLE;
         op           <= OP_READ;
         cnt          <= '0;
         idx          <= '0;
         base         <= '0;
         last_addr    <= '0;
         last_data    <= '0;
         polling      <= 1'b0;
         busy         <= 1'b0;
         byte_ready   <= 1'b0;
         rd_valid     <= 1'b0;
         rd_data      <= '0;
         done         <= 1'b0;
         err_window   <= 1'b0;
         err_poll     <= 1'b0;
         flash_ce_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         flash_addr   <= '0;
         flash_dq_out <= '0;
         flash_dq_oe  <= 1'b0;
         id_hv_en     <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         done     <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (cmd_valid) begin
                  op         <= pfh_op_t'(cmd_op);
                  busy       <= 1'b1;
                  base       <= cmd_addr;
                  idx        <= '0;
                  polling    <= 1'b0;
                  err_window <= 1'b0;
                  err_poll   <= 1'b0;
                  flash_ce_n <= 1'b0;
                  if (cmd_op == OP_READ || cmd_op == OP_ID) begin
                     // Hardware ID: only code select may be high
                     flash_addr <= (cmd_op == OP_ID) ? {15'h0000, cmd_addr[0]} : cmd_addr;
                     id_hv_en   <= (cmd_op == OP_ID);
                     flash_oe_n <= 1'b0;
                     cnt        <= CNT_W'(ACC_CYC - 1);
                     state      <= S_READ;
                  end else begin
                     // Program always opens with the command prefix
                     flash_addr   <= (cmd_op == OP_PROG) ? CMD_ADDRS[15:0] : cmd_addr;
                     flash_dq_out <= (cmd_op == OP_PROG) ? CMD_DATA[7:0] : cmd_wdata;
                     last_addr    <= cmd_addr;
                     last_data    <= cmd_wdata;
                     flash_dq_oe  <= 1'b1;
                     state        <= S_SETUP;
                  end
               end
            end
            S_SETUP: begin
               flash_we_n <= 1'b0;
               cnt        <= CNT_W'(WP_CYC - 1);
               state      <= S_WLOW;
            end
            S_WLOW: begin
               if (cnt == '0) begin
                  flash_we_n <= 1'b1;
                  idx        <= idx + 8'h01;
                  cnt        <= CNT_W'(WPH_CYC - 1);
                  state      <= S_WHIGH;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            S_WHIGH: begin
               // One cycle of data hold, then float
               flash_dq_oe <= 1'b0;
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else if (op == OP_WRITE) begin
                  flash_ce_n <= 1'b1;
                  busy       <= 1'b0;
                  done       <= 1'b1;
                  state      <= S_IDLE;
               end else if (idx < 8'(CMD_BYTES)) begin
                  flash_addr   <= CMD_ADDRS[idx[1:0]*16 +: 16];
                  flash_dq_out <= CMD_DATA[idx[1:0]*8 +: 8];
                  flash_dq_oe  <= 1'b1;
                  state        <= S_SETUP;
               end else if (idx < 8'(CMD_BYTES + SECTOR_BYTES)) begin
                  flash_ce_n <= 1'b1;
                  byte_ready <= 1'b1;
                  state      <= S_WAIT;
               end else begin
                  // Whole sector in: poll the last byte
                  flash_addr <= last_addr;
                  flash_oe_n <= 1'b0;
                  polling    <= 1'b1;
                  cnt        <= CNT_W'(ACC_CYC - 1);
                  state      <= S_READ;
               end
            end
            S_WAIT: begin
               if (byte_valid) begin
                  byte_ready   <= 1'b0;
                  flash_addr   <= {base[15:SECTOR_LSB], 7'(idx - 8'(CMD_BYTES))};
                  flash_dq_out <= byte_data;
                  last_addr    <= {base[15:SECTOR_LSB], 7'(idx - 8'(CMD_BYTES))};
                  last_data    <= byte_data;
                  flash_ce_n   <= 1'b0;
                  flash_dq_oe  <= 1'b1;
                  state        <= S_SETUP;
               end else if (since_we >= SINCE_W'(BLC_LIMIT - BLC_MARGIN)) begin
                  // Stream stalled: load period is about to close
                  byte_ready <= 1'b0;
                  err_window <= 1'b1;
                  flash_ce_n <= 1'b0;
                  flash_addr <= last_addr;
                  flash_oe_n <= 1'b0;
                  polling    <= 1'b1;
                  cnt        <= CNT_W'(ACC_CYC - 1);
                  state      <= S_READ;
               end
            end
            S_READ: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  rd_data    <= flash_dq_in;
                  rd_valid   <= !polling;
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  id_hv_en   <= 1'b0;
                  cnt        <= CNT_W'(DF_CYC - 1);
                  state      <= S_RECOV;
                  // Old data stands until the load window has surely closed
                  if (polling && since_we >= SINCE_W'(BLC_LIMIT + BLC_MARGIN) &&
                      flash_dq_in[POLL_BIT] == last_data[POLL_BIT]) begin
                     polling <= 1'b0;
                  end else if (polling && since_we >= SINCE_W'(BLC_LIMIT + WC_LIMIT)) begin
                     polling  <= 1'b0;
                     err_poll <= 1'b1;
                  end
               end
            end
            S_RECOV: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else if (polling) begin
                  flash_ce_n <= 1'b0;
                  flash_oe_n <= 1'b0;
                  cnt        <= CNT_W'(ACC_CYC - 1);
                  state      <= S_READ;
               end else begin
                  busy  <= 1'b0;
                  done  <= (op == OP_PROG);
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_we_fall;
      $fell(flash_we_n);
   endsequence

   sequence s_prog_start;
      state == S_IDLE && cmd_valid && cmd_op == OP_PROG;
   endsequence

   chk_oe_in_write: assert property (@(posedge core_clk) disable iff (!rstn)
      (!flash_we_n && !flash_ce_n) |-> flash_oe_n)
      else $error("output drive low during write");

   chk_load_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      s_we_fall |-> (!flash_ce_n && flash_dq_oe && !flash_we_n)[*8])
      else $error("byte load without driven data");

   chk_bus_release: assert property (@(posedge core_clk) disable iff (!rstn)
      flash_dq_oe |-> flash_oe_n && (state inside {S_SETUP, S_WLOW, S_WHIGH}))
      else $error("data bus driven outside a load");

   chk_hv_address: assert property (@(posedge core_clk) disable iff (!rstn)
      id_hv_en |-> flash_addr[15:1] == 15'h0000 && !flash_oe_n && flash_we_n)
      else $error("identification address not clean");

   chk_sector_lines: assert property (@(posedge core_clk) disable iff (!rstn)
      s_we_fall ##0 (op == OP_PROG && idx >= 8'(CMD_BYTES))
      |-> flash_addr[15:SECTOR_LSB] == base[15:SECTOR_LSB])
      else $error("sector number wrong at load");

   chk_cmd_first: assert property (@(posedge core_clk) disable iff (!rstn)
      s_prog_start |=> flash_addr == CMD_ADDRS[15:0] ##1 !flash_we_n)
      else $error("program did not open with prefix");

   chk_load_window: assert property (@(posedge core_clk) disable iff (!rstn)
      s_we_fall ##0 (op == OP_PROG && idx != 8'h00) |-> since_we < SINCE_W'(BLC_LIMIT))
      else $error("load window exceeded");

   chk_full_sector: assert property (@(posedge core_clk) disable iff (!rstn)
      ($rose(polling) && !err_window) |-> idx == 8'(CMD_BYTES + SECTOR_BYTES))
      else $error("polling before full sector loaded");

   chk_poll_bound: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == S_READ && polling)
      |-> since_we <= SINCE_W'(BLC_LIMIT + WC_LIMIT + ACC_CYC + DF_CYC + 2))
      else $error("polling past cycle maximum");

endmodule : pfh_flash_host

// ==== dv/pfh_flash_model.sv ====
`timescale 1ns/1ps
module pfh_flash_model
   import pfh_pkg::*;
#(
   parameter int          BLC   = 190,
   parameter int          WC    = 100,
   parameter logic [47:0] C_ADR = 48'h0003_0002_0001,
   parameter logic [23:0] C_DAT = 24'h03_0201,
   parameter logic [7:0]  MAKER = 8'h5C, // Arbitrary value
   parameter logic [7:0]  PART  = 8'hC5, // Arbitrary value
   parameter logic [7:0]  ID_ON = 8'h60, // Arbitrary value
   parameter logic [7:0]  ID_OFF = 8'h70 // Arbitrary value
)(
   // Host side pins
   input  wire logic        clk,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  host_dq,
   input  wire logic        host_oe,
   input  wire logic        hv,
   // Resolved data wire
   output logic      [7:0]  dq_wire
);
   logic [7:0]   mem [0:65535];
   logic [7:0]   sbuf [0:127];
   logic [127:0] got     = '0;
   logic [1:0]   pre     = 2'h0;
   logic         loading = 1'b0;
   logic         prog    = 1'b0;
   logic         sw_id   = 1'b0;
   logic         pwe     = 1'b1;
   logic [15:0]  last_a  = 16'h0000;
   logic [7:0]   last_d  = 8'h00;
   logic [7:0]   held    = 8'h00;
   logic [7:0]   dev;
   logic         rise;
   logic         drv;
   int           tmr     = 0;
   // Contents at power up
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
   end
   // Load edge and read drive conditions
   assign rise = we_n && !pwe && !ce_n && oe_n && !prog;
   assign drv  = !ce_n && !oe_n && we_n;
   // Read data source
   always_comb begin
      if (hv || sw_id) dev = addr[0] ? PART : MAKER;
      else if (prog && addr == last_a) dev = {~last_d[7], last_d[6:0]};
      else dev = mem[addr];
   end
   // Floating wire keeps changing so a stale value never looks valid
   assign dq_wire = host_oe ? host_dq : (drv ? dev : held);
   // Byte capture, load window and program cycle
   always @(posedge clk) begin
      pwe <= we_n;
      held <= ~dq_wire;
      if (rise) begin
         last_a <= addr;
         last_d <= host_dq;
         tmr <= 0;
         if (loading) begin
            sbuf[addr[6:0]] <= host_dq;
            got[addr[6:0]] <= 1'b1;
         end else if (pre == 2'h2 && addr == C_ADR[47:32] &&
                      (host_dq == ID_ON || host_dq == ID_OFF)) begin
            // Identification entry or exit instead of a program prefix
            pre <= 2'h0;
            sw_id <= (host_dq == ID_ON);
         end else if (addr == C_ADR[16*pre+:16] && host_dq == C_DAT[8*pre+:8]) begin
            pre <= (pre == 2'h2) ? 2'h0 : pre + 2'h1;
            loading <= (pre == 2'h2);
         end else begin
            pre <= 2'h0;
            prog <= 1'b1;
         end
      end else if (loading && tmr >= BLC) begin
         loading <= 1'b0;
         prog <= 1'b1;
         tmr <= 0;
      end else if (prog && tmr >= WC) begin
         prog <= 1'b0;
         got <= '0;
         for (int i = 0; i < 128; i++)
            if (got != '0) mem[{last_a[15:7], i[6:0]}] <= got[i] ? sbuf[i] : 8'hA5 ^ i[7:0];
      end else tmr <= tmr + 1;
   end
endmodule : pfh_flash_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
   import pfh_pkg::*;
   localparam logic [7:0] MAKER = 8'h5C; // Arbitrary value
   localparam logic [7:0] PART  = 8'hC5; // Arbitrary value
   localparam int         WC_M  = 100;
   localparam int         BLC_M = 200;
   localparam logic [7:0] ID_ON  = 8'h60; // Arbitrary value
   localparam logic [7:0] ID_OFF = 8'h70; // Arbitrary value
   logic        core_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, byte_valid = 1'b0;
   logic [1:0]  cmd_op = 2'h0;
   logic [15:0] cmd_addr = 16'h0000, f_addr;
   logic [7:0]  cmd_wdata = 8'h00, byte_data = 8'h00, rd_data, dq_out, dq_in;
   logic        busy, byte_ready, rd_valid, done, err_window, err_poll;
   logic        ce_n, oe_n, we_n, dq_oe, hv;
   int          err_count = 0, check_count = 0, cycles = 0, n;
   pfh_flash_host #(.BLC_LIMIT(200), .WC_LIMIT(500)) uut (.core_clk(core_clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .busy(busy), .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .err_window(err_window),
      .err_poll(err_poll), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_addr(f_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
      .id_hv_en(hv));
   pfh_flash_model #(.BLC(BLC_M), .WC(WC_M), .MAKER(MAKER), .PART(PART), .ID_ON(ID_ON),
      .ID_OFF(ID_OFF)) flash (.clk(core_clk),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .host_dq(dq_out),
      .host_oe(dq_oe), .hv(hv), .dq_wire(dq_in));
   // Clock and hang guard
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : check
   // Pin monitor on every cycle
   always @(negedge core_clk) begin
      if (!we_n && !ce_n) check("oe_n in load", 8'h01, {7'h00, oe_n});
      if (dq_oe) check("oe_n while driving", 8'h01, {7'h00, oe_n});
   end
   function automatic logic [7:0] pat(input logic [8:0] s, input int k);
      return 8'h3C ^ k[7:0] ^ s[7:0];
   endfunction : pat
   task automatic cmd(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      while (busy !== 1'b0) @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge core_clk);
      cmd_valid = 1'b0;
   endtask : cmd
   task automatic wait_for(input bit rd, output int cnt);
      cnt = 0;
      while ((rd ? rd_valid : done) !== 1'b1) begin
         @(negedge core_clk);
         cnt++;
      end
   endtask : wait_for
   task automatic rd(input logic [1:0] op, input logic [15:0] a, input logic [7:0] exp,
                     input string what);
      int c;
      cmd(op, a, 8'h00);
      wait_for(1'b1, c);
      check(what, exp, rd_data);
   endtask : rd
   task automatic prog(input logic [8:0] s, input int nb, output int cnt);
      cmd(OP_PROG, {s, 7'h00}, 8'h00);
      for (int k = 0; k < nb; k++) begin
         while (byte_ready !== 1'b1) @(negedge core_clk);
         byte_valid = 1'b1;
         byte_data = pat(s, k);
         @(negedge core_clk);
         byte_valid = 1'b0;
         while (byte_ready === 1'b1) @(negedge core_clk);
      end
      wait_for(1'b0, cnt);
   endtask : prog
   // Software identification entry or exit by three single writes
   task automatic sw_mode(input logic [7:0] code);
      cmd(OP_WRITE, 16'h0001, 8'h01);
      cmd(OP_WRITE, 16'h0002, 8'h02);
      cmd(OP_WRITE, 16'h0003, code);
   endtask : sw_mode
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   // Main sequence
   initial begin
      repeat (3) @(negedge core_clk);
      rstn = 1'b1;
      check("ce_n idle", 8'h01, {7'h00, ce_n});
      check("dq_oe idle", 8'h00, {7'h00, dq_oe});
      rd(OP_ID, 16'h0000, MAKER, "maker code");
      rd(OP_ID, 16'h0001, PART, "part code");
      rd(OP_READ, 16'h1234, 8'h26, "plain read");
      sw_mode(ID_ON);
      rd(OP_READ, 16'h0000, MAKER, "soft maker code");
      rd(OP_READ, 16'h0001, PART, "soft part code");
      sw_mode(ID_OFF);
      rd(OP_READ, 16'h0001, 8'h01, "read after id exit");
      cmd(OP_WRITE, 16'h0200, 8'h77);
      wait_for(1'b0, n);
      repeat (WC_M + 20) @(negedge core_clk);
      rd(OP_READ, 16'h0200, 8'h02, "write without prefix");
      prog(9'h009, 128, n);
      check("poll wait", 8'h01, {7'h00, n > BLC_M + WC_M});
      check("window err full", 8'h00, {7'h00, err_window});
      check("poll err", 8'h00, {7'h00, err_poll});
      rd(OP_READ, {9'h009, 7'h00}, pat(9'h009, 0), "sector first");
      rd(OP_READ, {9'h009, 7'h7F}, pat(9'h009, 127), "sector last");
      prog(9'h00A, 5, n);
      check("window err stall", 8'h01, {7'h00, err_window});
      rd(OP_READ, {9'h00A, 7'h04}, pat(9'h00A, 4), "stalled sector");
      summarize();
   end
endmodule : tb
